//--- design/bmr_pkg.sv
// Constants for the boot block map reset configuration loader
package bmr_pkg;
  // Field encodings of flash_map_field
  localparam logic [1:0] FIELD_POR_UNPROG = 2'h0;
  localparam logic [1:0] FIELD_POR_PROG   = 2'h1;
  localparam logic [1:0] FIELD_SW_UNPROG  = 2'h2;
  localparam logic [1:0] FIELD_SW_PROG    = 2'h3;
  localparam logic [1:0] FIELD_OVERLAY    = 2'h0;
  localparam logic [1:0] FIELD_RESET      = 2'h0;
  // Logic level of startup_map_bit when programmed
  localparam logic       MAP_BIT_PROG_LVL = 1'b0;
  localparam logic       MAP_BIT_ERASED   = 1'b1;
  // Low program range that the alternate block overlays
  localparam int         PC_WIDTH         = 16;
  localparam logic [15:0] OVERLAY_TOP     = 16'h1fff;
  // Reset cause encoding
  typedef enum logic [2:0] {
    BMR_CAUSE_NONE  = 3'h0,
    BMR_CAUSE_POR   = 3'h1,
    BMR_CAUSE_EXT   = 3'h3,
    BMR_CAUSE_WDOG  = 3'h2,
    BMR_CAUSE_BROWN = 3'h6,
    BMR_CAUSE_SOFT  = 3'h7
  } bmr_cause_t;
endpackage : bmr_pkg

//--- design/bmr_loader.sv
// Flash map field loader: reset-cause dependent init and fetch steering
`timescale 1ns/1ps
module bmr_loader (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Reset cause indications, held during the reset pulse
  input  wire logic        por_rst,
  input  wire logic        ext_rst,
  input  wire logic        watchdog_timer_rst,
  input  wire logic        brown_rst,
  input  wire logic        soft_rst,
  // Programming command to write the startup bit
  input  wire logic        prog_cmd,
  input  wire logic        host_prog_mode,
  input  wire logic        in_app_programming,
  input  wire logic        prog_map_bit,
  // Software write of field bit 0
  input  wire logic        sw_wr,
  input  wire logic        sw_bit0,
  // Fetch and programming address paths
  input  wire logic [15:0] fetch_pc,
  input  wire logic        prog_access,
  // Outputs
  output logic [1:0]       flash_map_field,
  output logic             startup_map_bit,
  output logic             fetch_alt_block,
  output logic             prog_alt_block
);

  // Non-volatile bit model; erased until a programming command
  logic       map_bit_q, map_bit_d;
  // Latched reset cause and the active field
  logic [2:0] cause_q, cause_d;
  logic       in_rst_q, in_rst_d;
  logic [1:0] field_q, field_d;
  logic       prog_sel;
  logic       low_range;

  // Cause capture: power-on has top priority, software the lowest
  always_comb begin
    cause_d  = cause_q;
    in_rst_d = 1'b0;
    if (por_rst) begin
      cause_d  = bmr_pkg::BMR_CAUSE_POR;
      in_rst_d = 1'b1;
    end else if (ext_rst) begin
      cause_d  = bmr_pkg::BMR_CAUSE_EXT;
      in_rst_d = 1'b1;
    end else if (watchdog_timer_rst) begin
      cause_d  = bmr_pkg::BMR_CAUSE_WDOG;
      in_rst_d = 1'b1;
    end else if (brown_rst) begin
      cause_d  = bmr_pkg::BMR_CAUSE_BROWN;
      in_rst_d = 1'b1;
    end else if (soft_rst) begin
      cause_d  = bmr_pkg::BMR_CAUSE_SOFT;
      in_rst_d = 1'b1;
    end
  end

  // Startup bit is only touched by a programming command in a prog mode
  always_comb begin
    map_bit_d = map_bit_q;
    if (prog_cmd && (host_prog_mode || in_app_programming)) begin
      map_bit_d = prog_map_bit;
    end
  end

  assign prog_sel = (map_bit_q == bmr_pkg::MAP_BIT_PROG_LVL);

  // Field load when a reset source falls away, else software bit 0
  always_comb begin
    field_d = field_q;
    if (in_rst_q && !in_rst_d) begin
      case (cause_q)
        bmr_pkg::BMR_CAUSE_POR, bmr_pkg::BMR_CAUSE_EXT: begin
          field_d = prog_sel ? bmr_pkg::FIELD_POR_PROG
                             : bmr_pkg::FIELD_POR_UNPROG;
        end
        bmr_pkg::BMR_CAUSE_WDOG, bmr_pkg::BMR_CAUSE_BROWN: begin
          field_d = {field_q[1], prog_sel};
        end
        bmr_pkg::BMR_CAUSE_SOFT: begin
          field_d = prog_sel ? bmr_pkg::FIELD_SW_PROG
                             : bmr_pkg::FIELD_SW_UNPROG;
        end
        default: field_d = field_q;
      endcase
    end else if (!in_rst_q && !in_rst_d && sw_wr) begin
      field_d = {field_q[1], sw_bit0};
    end
  end

  // Startup bit register; the volatile model starts erased on rstn,
  // a real part would keep its programmed state across power cycles
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      map_bit_q <= bmr_pkg::MAP_BIT_ERASED;
    end else begin
      map_bit_q <= map_bit_d;
    end
  end

  // Cause registers; no cause latched until a source is seen
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cause_q  <= bmr_pkg::BMR_CAUSE_NONE;
      in_rst_q <= 1'b0;
    end else begin
      cause_q  <= cause_d;
      in_rst_q <= in_rst_d;
    end
  end

  // Field register; rstn models power-on with an erased startup bit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      field_q <= bmr_pkg::FIELD_RESET;
    end else begin
      field_q <= field_d;
    end
  end

  // Overlay decode; code toggling from the low range is software's risk,
  // since the fetch source under it changes with the next instruction
  assign low_range       = (fetch_pc <= bmr_pkg::OVERLAY_TOP);
  assign fetch_alt_block = low_range &&
                           (field_q == bmr_pkg::FIELD_OVERLAY);
  // Alternate block reachable by the programming path when not overlaid
  assign prog_alt_block  = prog_access &&
                           (field_q != bmr_pkg::FIELD_OVERLAY);
  // Outputs straight from the registers
  assign flash_map_field = field_q;
  assign startup_map_bit = map_bit_q;

  // Software write of bit 0 lands one cycle later, outside any reset
  chk_sw_bit0_write: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !in_rst_q && !in_rst_d && sw_wr
      |=> flash_map_field[0] == $past(sw_bit0))
    else $error("software bit 0 write lost");
  // A software write never reaches the startup bit
  chk_sw_keeps_bit: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    sw_wr && !prog_cmd |=> $stable(startup_map_bit))
    else $error("startup bit changed by software write");
  // Without a command in a programming mode the startup bit holds
  chk_prog_only: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !(prog_cmd && (host_prog_mode || in_app_programming))
      |=> $stable(startup_map_bit))
    else $error("startup bit changed without command");
  // An accepted command stores the requested level
  chk_prog_store: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    prog_cmd && (host_prog_mode || in_app_programming)
      |=> startup_map_bit == $past(prog_map_bit))
    else $error("programming command not stored");

  // Power-on and external loads: 00 erased, 01 programmed
  chk_por_load: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    in_rst_q && !in_rst_d && (cause_q == bmr_pkg::BMR_CAUSE_POR)
      |=> flash_map_field == {1'b0, !$past(startup_map_bit)})
    else $error("power-on field value wrong");
  chk_ext_load: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    in_rst_q && !in_rst_d && (cause_q == bmr_pkg::BMR_CAUSE_EXT)
      |=> flash_map_field == {1'b0, !$past(startup_map_bit)})
    else $error("external reset field value wrong");
  // Software reset load: 10 erased, 11 programmed
  chk_soft_load: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    in_rst_q && !in_rst_d && (cause_q == bmr_pkg::BMR_CAUSE_SOFT)
      |=> flash_map_field == {1'b1, !$past(startup_map_bit)})
    else $error("software reset field value wrong");
  // Watchdog and brown-out loads touch only the low bit
  chk_wdog_keep: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    in_rst_q && !in_rst_d && (cause_q == bmr_pkg::BMR_CAUSE_WDOG)
      |=> flash_map_field[1] == $past(flash_map_field[1]))
    else $error("watchdog reset changed high bit");
  chk_wdog_low: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    in_rst_q && !in_rst_d && (cause_q == bmr_pkg::BMR_CAUSE_WDOG)
      |=> flash_map_field[0] == !$past(startup_map_bit))
    else $error("watchdog reset low bit wrong");
  chk_brown_load: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    in_rst_q && !in_rst_d && (cause_q == bmr_pkg::BMR_CAUSE_BROWN)
      |=> flash_map_field == {$past(flash_map_field[1]),
                              !$past(startup_map_bit)})
    else $error("brown-out field value wrong");
  // Field moves only on a load or an accepted software write
  chk_field_hold: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !in_rst_q && !sw_wr |=> $stable(flash_map_field))
    else $error("field changed without load or write");

  // Alternate fetch only inside the low range with field 00
  chk_overlay_fetch: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    fetch_alt_block |-> flash_map_field == 2'h0 && fetch_pc[15:13] == 3'h0)
    else $error("alternate fetch outside overlay");
  chk_overlay_hit: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    flash_map_field == 2'h0 && fetch_pc[15:13] == 3'h0 |-> fetch_alt_block)
    else $error("overlay fetch missed");
  // Other field values hide the alternate block from fetch, and field 00 hides it from the programming path
  chk_alt_hidden: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    flash_map_field != 2'h0 |-> !fetch_alt_block)
    else $error("alternate block visible");
  chk_prog_alt: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    flash_map_field == 2'h0 |-> !prog_alt_block)
    else $error("programming path reached overlaid block");

endmodule : bmr_loader

//--- tb/tb_top.sv
// Self-checking bench for the flash map field loader
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk, rstn, prog_cmd, host_prog_mode, in_app_programming;
  logic        prog_map_bit, sw_wr, sw_bit0, prog_access;
  logic [4:0]  cz;
  logic [15:0] fetch_pc;
  logic [1:0]  flash_map_field;
  logic        startup_map_bit, fetch_alt_block, prog_alt_block;
  int          n_errors, n_checks;
  // Cause index 0 por, 1 ext, 2 wdog, 3 brown, 4 soft
  typedef struct packed {
    logic [2:0] c;
    logic       b;
    logic       m;
    logic [1:0] f;
  } bmr_row_t;
  // Ordered so that wdog and brown rows see a known high bit
  bmr_row_t rows [9] = '{'{3'h0, 1'b1, 1'b0, 2'h0}, '{3'h1, 1'b0, 1'b1, 2'h1},
    '{3'h4, 1'b1, 1'b0, 2'h2}, '{3'h2, 1'b0, 1'b1, 2'h3},
    '{3'h3, 1'b1, 1'b0, 2'h2}, '{3'h4, 1'b0, 1'b1, 2'h3},
    '{3'h0, 1'b1, 1'b1, 2'h0}, '{3'h2, 1'b0, 1'b0, 2'h1},
    '{3'h3, 1'b1, 1'b1, 2'h0}};
  bmr_loader dut_u (.sys_clk(sys_clk), .rstn(rstn), .por_rst(cz[0]),
    .ext_rst(cz[1]), .watchdog_timer_rst(cz[2]), .brown_rst(cz[3]),
    .soft_rst(cz[4]), .prog_cmd(prog_cmd), .host_prog_mode(host_prog_mode),
    .in_app_programming(in_app_programming), .prog_map_bit(prog_map_bit),
    .sw_wr(sw_wr), .sw_bit0(sw_bit0), .fetch_pc(fetch_pc),
    .prog_access(prog_access), .flash_map_field(flash_map_field),
    .startup_map_bit(startup_map_bit), .fetch_alt_block(fetch_alt_block),
    .prog_alt_block(prog_alt_block));
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic pulse(input int i);
    cz[i] = 1'b1;
    step(1);
    cz = 5'h0_0;
    step(2);
  endtask : pulse
  task automatic prog(input logic b, input logic m, input logic en);
    host_prog_mode = en & ~m;
    in_app_programming = en & m;
    prog_map_bit = b;
    prog_cmd = 1'b1;
    step(1);
    {prog_cmd, host_prog_mode, in_app_programming} = 3'h0;
    step(1);
  endtask : prog
  task automatic sw(input logic b);
    sw_wr = 1'b1;
    sw_bit0 = b;
    step(1);
    sw_wr = 1'b0;
    step(1);
  endtask : sw
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // Hang guard
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    {rstn, prog_cmd, host_prog_mode, in_app_programming} = 4'h0;
    {prog_map_bit, sw_wr, sw_bit0, prog_access} = 4'h1;
    cz = 5'h0_0;
    fetch_pc = 16'h0000;
    n_errors = 0;
    n_checks = 0;
    step(6);
    rstn = 1'b1;
    chk(flash_map_field, 2'h0);
    chk(startup_map_bit, 1'b1);
    for (int i = 0; i < 9; i++) begin
      prog(rows[i].b, rows[i].m, 1'b1);
      chk(startup_map_bit, rows[i].b);
      pulse(rows[i].c);
      chk(flash_map_field, rows[i].f);
      fetch_pc = 16'h1fff;
      step(1);
      chk(fetch_alt_block, rows[i].f == 2'h0);
      chk(prog_alt_block, rows[i].f != 2'h0);
      fetch_pc = 16'h2000;
      step(1);
      chk(fetch_alt_block, 1'b0);
    end
    // Command outside both programming modes is ignored
    prog(1'b0, 1'b0, 1'b0);
    chk(startup_map_bit, 1'b1);
    // Toggle issued from above the overlay, pc still at 2000
    sw(1'b1);
    chk(flash_map_field, 2'h1);
    chk(startup_map_bit, 1'b1);
    // Programming path closed when no access is requested
    chk(prog_alt_block, 1'b1);
    prog_access = 1'b0;
    step(1);
    chk(prog_alt_block, 1'b0);
    // Software write overlapping a reset is refused, then the load wins
    cz[4] = 1'b1;
    sw(1'b0);
    chk(flash_map_field, 2'h1);
    cz = 5'h00;
    step(1);
    chk(flash_map_field, 2'h2);
    // Power-on and software sources together: power-on value wins
    cz = 5'h11;
    step(1);
    cz = 5'h00;
    step(2);
    chk(flash_map_field, 2'h0);
    // Second power-on reset in mid-run
    prog(1'b0, 1'b1, 1'b1);
    rstn = 1'b0;
    step(1);
    rstn = 1'b1;
    chk(flash_map_field, 2'h0);
    chk(startup_map_bit, 1'b1);
    finish_test();
  end
endmodule : tb_top
